// >>> hw/gicd_decoder.v
/*
 * Initialization and status command decoder. Takes one whole command
 * (identifier, payload length, up to twelve payload bytes, little byte
 * index 0 in the low bits) per valid pulse and updates the stored
 * initial position, aiding position, time and 2-D altitude, and issues
 * report requests one at a time on the report port.
 * Assumes framing and float decoding live upstream, and that the report
 * sender accepts one report per cycle that rpt_ready is high.
 */
`timescale 1ns/1ns
`default_nettype none
`include "gicd_map.vh"

module gicd_decoder #(
   parameter SELFTEST_CYC = `GICD_SELFTEST_CYC
)(
   // Clock and reset
   input wire clock,
   input wire reset_n,
   // Command in
   input wire cmd_valid,
   input wire [7:0] cmd_id,
   input wire [3:0] cmd_len,
   input wire [95:0] cmd_data,
   output reg cmd_ready_ff,
   // Receiver status
   input wire pos_solving,
   input wire time_from_sv,
   input wire alt_in_msl,
   // Report out
   output reg rpt_valid_ff,
   output reg [7:0] rpt_id_ff,
   output reg [3:0] rpt_len_ff,
   input wire rpt_ready,
   // Stored parameters
   output reg [95:0] init_pos_ff,
   output reg init_pos_lla_ff,
   output reg init_pos_upd_ff,
   output reg [95:0] aid_pos_ff,
   output reg aid_pos_upd_ff,
   output reg [31:0] tow_ff,
   output reg [15:0] week_ff,
   output reg time_upd_ff,
   output reg [31:0] ref_alt_ff,
   output reg alt_flag_ff,
   output reg alt_ref_msl_ff,
   // Soft reset
   output reg restart_ff,
   output reg selftest_busy_ff
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_RPT1 = 3'h1;
   localparam ST_RPT2 = 3'h2;
   localparam ST_TEST = 3'h3;
   localparam ST_BOOT = 3'h4;

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [7:0] rpt2_ff;
   reg [7:0] nxt_rpt2;
   reg [15:0] cnt_ff;
   reg [15:0] nxt_cnt;
   reg [7:0] nxt_rpt_id;
   reg [3:0] nxt_rpt_len;
   reg nxt_rpt_valid;

   // Payload length check per identifier; shared by accept and reply
   function len_ok;
      input [7:0] id;
      input [3:0] len;
      begin
         case (id)
            `GICD_CMD_POS_XYZ, `GICD_CMD_POS_LLA, `GICD_CMD_ACC_XYZ:
               len_ok = (len == `GICD_LEN_POS);
            `GICD_CMD_SET_TIME:
               len_ok = (len == `GICD_LEN_TIME);
            `GICD_CMD_ALT_2D:
               len_ok = (len == `GICD_LEN_NONE) ||
                        (len == `GICD_LEN_ALT_SET) ||
                        (len == `GICD_LEN_ALT_CLR);
            `GICD_CMD_FIX_REQ, `GICD_CMD_SOFT_RST, `GICD_CMD_HEALTH,
            `GICD_CMD_SIGNAL, `GICD_CMD_OSC_REQ, `GICD_CMD_VER_REQ:
               len_ok = (len == `GICD_LEN_NONE);
            default:
               len_ok = 1'b0;
         endcase
      end
   endfunction

   wire take = cmd_valid && cmd_ready_ff;
   wire good = take && len_ok(cmd_id, cmd_len);
   wire alt_clr = cmd_data[7:0] == `GICD_ALT_CLR_VAL;

   // ****************************************************************
   // Reply sequencing
   // ****************************************************************
   // Only one report is offered at a time, so commands stall while
   // a report is pending rather than being buffered.
   always @*
   begin
      nxt_state = state_ff;
      nxt_rpt2 = rpt2_ff;
      nxt_cnt = cnt_ff;
      nxt_rpt_valid = rpt_valid_ff;
      nxt_rpt_id = rpt_id_ff;
      nxt_rpt_len = rpt_len_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (good)
            begin
               nxt_rpt_len = `GICD_LEN_NONE;
               nxt_rpt_id = `GICD_RPT_NONE;
               case (cmd_id)
                  `GICD_CMD_FIX_REQ:
                     nxt_rpt_id = `GICD_RPT_FIX_MODE;
                  `GICD_CMD_HEALTH:
                  begin
                     nxt_rpt_id = `GICD_RPT_HEALTH;
                     nxt_rpt2 = `GICD_RPT_STATUS;
                  end
                  `GICD_CMD_SIGNAL:
                     nxt_rpt_id = `GICD_RPT_SIGNAL;
                  `GICD_CMD_OSC_REQ:
                     nxt_rpt_id = `GICD_RPT_OSC;
                  `GICD_CMD_VER_REQ:
                     nxt_rpt_id = `GICD_RPT_VERSION;
                  `GICD_CMD_ALT_2D:
                     if (cmd_len == `GICD_LEN_NONE)
                     begin
                        nxt_rpt_id = `GICD_RPT_ALT;
                        nxt_rpt_len = `GICD_ALT_RPT_LEN;
                     end
                  `GICD_CMD_SET_TIME:
                     if (!time_from_sv)
                        nxt_rpt_id = `GICD_RPT_TIME_ACK;
                  default:
                     nxt_rpt_id = `GICD_RPT_NONE;
               endcase
               if (cmd_id == `GICD_CMD_SOFT_RST)
               begin
                  nxt_state = ST_TEST;
                  nxt_cnt = 16'h0000;
               end
               else if (nxt_rpt_id != `GICD_RPT_NONE)
               begin
                  nxt_rpt_valid = 1'b1;
                  nxt_state = ST_RPT1;
               end
            end
         end
         ST_RPT1:
            if (rpt_ready)
            begin
               if (rpt2_ff != `GICD_RPT_NONE)
               begin
                  nxt_rpt_id = rpt2_ff;
                  nxt_rpt2 = `GICD_RPT_NONE;
                  nxt_state = ST_RPT2;
               end
               else
               begin
                  nxt_rpt_valid = 1'b0;
                  nxt_state = ST_IDLE;
               end
            end
         ST_RPT2:
            if (rpt_ready)
            begin
               nxt_rpt_valid = 1'b0;
               nxt_state = ST_IDLE;
            end
         ST_TEST:
            // Self-test runs for a fixed count, then boot messages
            if (cnt_ff == SELFTEST_CYC[15:0] - 16'h0001)
               nxt_state = ST_BOOT;
            else
               nxt_cnt = cnt_ff + 16'h0001;
         ST_BOOT:
         begin
            nxt_rpt_valid = 1'b1;
            nxt_rpt_id = `GICD_RPT_VERSION;
            nxt_rpt_len = `GICD_LEN_NONE;
            nxt_state = ST_RPT1;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Power-up starts at the boot step without self-test: the version report goes out first
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         state_ff <= ST_BOOT;
         rpt2_ff <= `GICD_RPT_NONE;
         cnt_ff <= 16'h0000;
         rpt_valid_ff <= 1'b0;
         rpt_id_ff <= `GICD_RPT_NONE;
         rpt_len_ff <= `GICD_LEN_NONE;
         cmd_ready_ff <= 1'b0;
         init_pos_ff <= 96'h0;
         init_pos_lla_ff <= 1'b0;
         init_pos_upd_ff <= 1'b0;
         aid_pos_ff <= 96'h0;
         aid_pos_upd_ff <= 1'b0;
         tow_ff <= 32'h0;
         week_ff <= 16'h0;
         time_upd_ff <= 1'b0;
         ref_alt_ff <= 32'h0;
         alt_flag_ff <= 1'b0;
         alt_ref_msl_ff <= 1'b0;
         restart_ff <= 1'b0;
         selftest_busy_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         rpt2_ff <= nxt_rpt2;
         cnt_ff <= nxt_cnt;
         rpt_valid_ff <= nxt_rpt_valid;
         rpt_id_ff <= nxt_rpt_id;
         rpt_len_ff <= nxt_rpt_len;
         cmd_ready_ff <= (nxt_state == ST_IDLE);
         init_pos_upd_ff <= 1'b0;
         aid_pos_upd_ff <= 1'b0;
         time_upd_ff <= 1'b0;
         restart_ff <= good && (cmd_id == `GICD_CMD_SOFT_RST);
         selftest_busy_ff <= (nxt_state == ST_TEST);
         // Datum of reference altitude follows the live I/O option
         alt_ref_msl_ff <= alt_in_msl;
         if (good)
         begin
            case (cmd_id)
               `GICD_CMD_POS_XYZ, `GICD_CMD_POS_LLA:
                  if (!pos_solving)
                  begin
                     init_pos_ff <= cmd_data;
                     init_pos_lla_ff <= (cmd_id == `GICD_CMD_POS_LLA);
                     init_pos_upd_ff <= 1'b1;
                  end
               `GICD_CMD_ACC_XYZ:
               begin
                  aid_pos_ff <= cmd_data;
                  aid_pos_upd_ff <= 1'b1;
               end
               `GICD_CMD_SET_TIME:
                  if (!time_from_sv)
                  begin
                     tow_ff <= cmd_data[31:0];
                     week_ff <= cmd_data[47:32];
                     time_upd_ff <= 1'b1;
                  end
               `GICD_CMD_ALT_2D:
                  if (cmd_len == `GICD_LEN_ALT_SET)
                  begin
                     ref_alt_ff <= cmd_data[31:0];
                     alt_flag_ff <= 1'b1;
                  end
                  else if (cmd_len == `GICD_LEN_ALT_CLR && alt_clr)
                     alt_flag_ff <= 1'b0;
               default:
                  alt_flag_ff <= alt_flag_ff;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// >>> hw/gicd_map.vh
/*
 * Constants for the initialization command decoder: command and report
 * identifiers, payload lengths and field positions.
 * Assumes packet framing is stripped upstream; identifiers are 8 bits.
 */
`ifndef GICD_MAP_VH
`define GICD_MAP_VH

// ****************************************************************
// Command identifiers
// ****************************************************************
`define GICD_CMD_POS_XYZ 8'h23
`define GICD_CMD_FIX_REQ 8'h24
`define GICD_CMD_SOFT_RST 8'h25
`define GICD_CMD_HEALTH 8'h26
`define GICD_CMD_SIGNAL 8'h27
`define GICD_CMD_ALT_2D 8'h2A
`define GICD_CMD_POS_LLA 8'h2B
`define GICD_CMD_OSC_REQ 8'h2D
`define GICD_CMD_SET_TIME 8'h2E
`define GICD_CMD_ACC_XYZ 8'h31
`define GICD_CMD_VER_REQ 8'h1F

// ****************************************************************
// Report identifiers
// ****************************************************************
`define GICD_RPT_NONE 8'h00
`define GICD_RPT_VERSION 8'h45
`define GICD_RPT_HEALTH 8'h46
`define GICD_RPT_SIGNAL 8'h47
`define GICD_RPT_ALT 8'h4A
`define GICD_RPT_STATUS 8'h4B
`define GICD_RPT_OSC 8'h4D
`define GICD_RPT_TIME_ACK 8'h4E
`define GICD_RPT_FIX_MODE 8'h6D

// ****************************************************************
// Payload lengths and field positions
// ****************************************************************
`define GICD_LEN_POS 4'hC
`define GICD_LEN_TIME 4'h6
`define GICD_LEN_ALT_SET 4'h4
`define GICD_LEN_ALT_CLR 4'h1
`define GICD_LEN_NONE 4'h0
`define GICD_ALT_CLR_VAL 8'hFF
`define GICD_ALT_RPT_LEN 4'h9
`define GICD_FLD_A_LSB 0
`define GICD_FLD_B_LSB 32
`define GICD_FLD_C_LSB 64
`define GICD_WEEK_LSB 32
`define GICD_EPOCH_YEAR 1980

// ****************************************************************
// Timing: self-test length of the soft reset, in cycles
// ****************************************************************
`define GICD_SELFTEST_CYC 16

`endif

// >>> verif/gicd_chk_sva.sv
/* Port checker for gicd_decoder.
   Assumes one clock and a synchronous, active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module gicd_chk (
   // Clock and command side
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_id,
   input wire logic [3:0] cmd_len,
   input wire logic cmd_ready_ff,
   input wire logic pos_solving,
   input wire logic time_from_sv,
   // Report side and pulses
   input wire logic rpt_valid_ff,
   input wire logic [7:0] rpt_id_ff,
   input wire logic [3:0] rpt_len_ff,
   input wire logic rpt_ready,
   input wire logic init_pos_upd_ff,
   input wire logic aid_pos_upd_ff,
   input wire logic time_upd_ff,
   input wire logic restart_ff,
   input wire logic selftest_busy_ff
);
   // ***************
   // Properties
   // ***************
   wire tk = cmd_valid && cmd_ready_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Report request as offered to the sink
   sequence s_rpt(logic [7:0] id);
      rpt_valid_ff && rpt_id_ff == id;
   endsequence
   // Payload-free request answered next cycle
   property p_req(logic [7:0] c, logic [7:0] r);
      tk && cmd_id == c && cmd_len == 4'h0 |=> s_rpt(r);
   endproperty
   AST_FIX: assert property (p_req(8'h24, 8'h6D))
      else $error("fix mode report missing");
   AST_HLTH: assert property (p_req(8'h26, 8'h46))
      else $error("health report missing");
   AST_PAIR: assert property (s_rpt(8'h46) ##0 rpt_ready |=> s_rpt(8'h4B))
      else $error("status report not after health");
   AST_SIG: assert property (p_req(8'h27, 8'h47))
      else $error("signal report missing");
   AST_OSC: assert property (p_req(8'h2D, 8'h4D))
      else $error("offset report missing");
   AST_QRY: assert property (tk && cmd_id == 8'h2A && cmd_len == 4'h0
      |=> s_rpt(8'h4A) ##0 rpt_len_ff == 4'h9) else $error("bad query");
   AST_TIME: assert property (tk && cmd_id == 8'h2E &&
      cmd_len == 4'h6 |=> rpt_valid_ff != $past(time_from_sv) &&
      (!rpt_valid_ff || rpt_id_ff == 8'h4E)) else $error("bad time ack");
   AST_DROP: assert property (tk && pos_solving &&
      (cmd_id == 8'h23 || cmd_id == 8'h2B) |=> !init_pos_upd_ff &&
      !rpt_valid_ff) else $error("position taken while solving");
   AST_BAD: assert property (tk && cmd_id == 8'h24 && cmd_len != 4'h0
      |=> cmd_ready_ff && !rpt_valid_ff) else $error("bad length used");
   AST_RST: assert property (tk && cmd_id == 8'h25 && cmd_len == 4'h0
      |=> restart_ff ##1 !restart_ff) else $error("restart not a pulse");
   // Self-test holds off commands and reports in the cycle of the restart pulse
   AST_BUSY: assert property (restart_ff |-> selftest_busy_ff &&
      !cmd_ready_ff && !rpt_valid_ff) else $error("restart not in self-test");
   AST_TUPD: assert property (tk && cmd_id == 8'h2E &&
      cmd_len == 4'h6 |=> time_upd_ff != $past(time_from_sv))
      else $error("bad time update");
   AST_AUPD: assert property (tk && cmd_id == 8'h31 &&
      cmd_len == 4'hC |=> aid_pos_upd_ff) else $error("aid not stored");
   AST_PUPD: assert property (tk && !pos_solving && cmd_len == 4'hC &&
      (cmd_id == 8'h23 || cmd_id == 8'h2B) |=> init_pos_upd_ff)
      else $error("initial position not stored");
endmodule
bind gicd_decoder gicd_chk u_chk (
   .clock(clock),
   .reset_n(reset_n),
   .cmd_valid(cmd_valid),
   .cmd_id(cmd_id),
   .cmd_len(cmd_len),
   .cmd_ready_ff(cmd_ready_ff),
   .pos_solving(pos_solving),
   .time_from_sv(time_from_sv),
   .rpt_valid_ff(rpt_valid_ff),
   .rpt_id_ff(rpt_id_ff),
   .rpt_len_ff(rpt_len_ff),
   .rpt_ready(rpt_ready),
   .init_pos_upd_ff(init_pos_upd_ff),
   .aid_pos_upd_ff(aid_pos_upd_ff),
   .time_upd_ff(time_upd_ff),
   .restart_ff(restart_ff),
   .selftest_busy_ff(selftest_busy_ff)
);
`default_nettype wire

// >>> verif/gicd_host_sink.sv
/* Report sink standing for the host on the report port.
   Assumes a report is held until rpt_ready is seen high. */
`timescale 1ns/1ns
`default_nettype none
module gicd_host_sink (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Report port, pacing and log
   input wire logic rpt_valid_ff,
   input wire logic [7:0] rpt_id_ff,
   input wire logic [1:0] stall,
   output var logic rpt_ready,
   output var logic [7:0] last_id_ff,
   output var logic [7:0] n_rpt_ff
);
   logic [1:0] wait_ff;
   // Ready after a stall; dropped after each take so pairs are seen
   always @(posedge clock)
   begin
      wait_ff <= (rpt_valid_ff && !rpt_ready) ? wait_ff + 2'h1 : 2'h0;
      rpt_ready <= reset_n && rpt_valid_ff && !rpt_ready && wait_ff == stall;
      if (!reset_n)
         n_rpt_ff <= 8'h00;
      else if (rpt_ready && rpt_valid_ff)
         n_rpt_ff <= n_rpt_ff + 8'h01;
      if (rpt_ready && rpt_valid_ff)
         last_id_ff <= rpt_id_ff;
   end
endmodule
`default_nettype wire

// >>> verif/tb_gicd_decoder.sv
/* Testbench for gicd_decoder: command table, then hand tests.
   Assumes the host sink model and the bound port checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_gicd_decoder;
   // Rows: id, len, solving, sv time, report count, last report
   localparam logic [23:0] ROWS [16] = '{24'h24016D, 24'h26024B,
      24'h270147, 24'h2A014A, 24'h2D014D, 24'h2E614E, 24'h2E6400,
      24'h23C800, 24'h2BC800, 24'h23C000, 24'h31C000, 24'h2A4000,
      24'h2A1000, 24'h243000, 24'h1F0145, 24'h2E5000};
   localparam logic [95:0] PAT = 96'h0C0B0A0908070605_04030201;
   logic clock = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0;
   logic pos_solving = 1'b0, time_from_sv = 1'b0, alt_in_msl = 1'b0;
   logic [7:0] cmd_id = 8'h00;
   logic [3:0] cmd_len = 4'h0;
   logic [95:0] cmd_data = 96'h0, init_pos_ff, aid_pos_ff;
   logic [1:0] stall = 2'h0;
   logic rpt_ready, cmd_ready_ff, rpt_valid_ff, init_pos_lla_ff;
   logic init_pos_upd_ff, aid_pos_upd_ff, time_upd_ff, alt_flag_ff;
   logic alt_ref_msl_ff, restart_ff, selftest_busy_ff;
   logic [7:0] rpt_id_ff, last_id_ff, n_rpt_ff, n0;
   logic [3:0] rpt_len_ff;
   logic [31:0] tow_ff, ref_alt_ff;
   logic [15:0] week_ff;
   int n_mismatch = 0, check_count = 0;
   // Clock, design and host side; short self-test keeps runs brief
   always #10 clock = ~clock;
   gicd_decoder #(.SELFTEST_CYC(2)) DUT (
      .clock(clock),
      .reset_n(reset_n),
      .cmd_valid(cmd_valid),
      .cmd_id(cmd_id),
      .cmd_len(cmd_len),
      .cmd_data(cmd_data),
      .cmd_ready_ff(cmd_ready_ff),
      .pos_solving(pos_solving),
      .time_from_sv(time_from_sv),
      .alt_in_msl(alt_in_msl),
      .rpt_valid_ff(rpt_valid_ff),
      .rpt_id_ff(rpt_id_ff),
      .rpt_len_ff(rpt_len_ff),
      .rpt_ready(rpt_ready),
      .init_pos_ff(init_pos_ff),
      .init_pos_lla_ff(init_pos_lla_ff),
      .init_pos_upd_ff(init_pos_upd_ff),
      .aid_pos_ff(aid_pos_ff),
      .aid_pos_upd_ff(aid_pos_upd_ff),
      .tow_ff(tow_ff),
      .week_ff(week_ff),
      .time_upd_ff(time_upd_ff),
      .ref_alt_ff(ref_alt_ff),
      .alt_flag_ff(alt_flag_ff),
      .alt_ref_msl_ff(alt_ref_msl_ff),
      .restart_ff(restart_ff),
      .selftest_busy_ff(selftest_busy_ff)
   );
   gicd_host_sink u_sink (
      .clock(clock),
      .reset_n(reset_n),
      .rpt_valid_ff(rpt_valid_ff),
      .rpt_id_ff(rpt_id_ff),
      .stall(stall),
      .rpt_ready(rpt_ready),
      .last_id_ff(last_id_ff),
      .n_rpt_ff(n_rpt_ff)
   );
   // Compare and count
   task chk(input logic [95:0] got, input logic [95:0] exp);
   begin
      check_count++;
      if (got !== exp)
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      n_mismatch += (got !== exp);
   end
   endtask
   // Verdict; a hang arrives here with hung set
   task close_out(input int hung);
   begin
      n_mismatch += hung;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   // Bounded wait for the decoder to take commands again
   task wait_rdy;
      int i;
   begin
      for (i = 0; i < 300 && (i == 0 || cmd_ready_ff !== 1'b1); i++)
         @(posedge clock) #1;
      if (cmd_ready_ff !== 1'b1)
         close_out(1);
   end
   endtask
   // One whole command, held for the single taking edge
   task do_cmd(input logic [7:0] id, input logic [3:0] len,
      input logic [95:0] d, input logic ps, input logic tsv);
   begin
      wait_rdy();
      @(posedge clock);
      {cmd_valid, cmd_id, cmd_len, cmd_data, pos_solving, time_from_sv}
         <= {1'b1, id, len, d, ps, tsv};
      @(posedge clock);
      cmd_valid <= 1'b0;
      wait_rdy();
   end
   endtask
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clock);
      #1;
      chk({cmd_ready_ff, rpt_valid_ff, restart_ff}, 3'h0);
      @(posedge clock);
      reset_n <= 1'b1;
      wait_rdy();
      chk({n_rpt_ff, last_id_ff}, 16'h0145);
      $display("reset test done");
      for (int k = 0; k < 16; k++)
      begin
         stall <= k[1:0];
         n0 = n_rpt_ff;
         do_cmd(ROWS[k][23:16], ROWS[k][15:12], PAT + k, ROWS[k][11],
            ROWS[k][10]);
         chk(n_rpt_ff - n0, ROWS[k][9:8]);
         if (ROWS[k][9:8] != 2'h0)
            chk(last_id_ff, ROWS[k][7:0]);
         $display("row %0d done", k);
      end
      chk({week_ff, tow_ff}, PAT[47:0] + 48'h5);
      chk(init_pos_ff, PAT + 96'h9);
      chk(aid_pos_ff, PAT + 96'hA);
      chk({alt_flag_ff, ref_alt_ff}, {1'b1, PAT[31:0] + 32'hB});
      do_cmd(8'h2A, 4'h1, 96'hFF, 1'b0, 1'b0);
      do_cmd(8'h2B, 4'hC, PAT, 1'b0, 1'b0);
      chk({alt_flag_ff, init_pos_lla_ff, init_pos_ff}, {2'h1, PAT});
      @(posedge clock);
      alt_in_msl <= 1'b1;
      repeat (2) @(posedge clock) #1;
      chk(alt_ref_msl_ff, 1'b1);
      n0 = n_rpt_ff;
      do_cmd(8'h25, 4'h0, PAT, 1'b0, 1'b0);
      chk({n_rpt_ff - n0, last_id_ff}, 16'h0145);
      $display("hand tests done");
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (3) @(posedge clock) #1;
      chk({cmd_ready_ff, rpt_valid_ff, alt_ref_msl_ff}, 3'h0);
      @(posedge clock);
      reset_n <= 1'b1;
      wait_rdy();
      chk({n_rpt_ff, last_id_ff}, 16'h0145);
      $display("second reset done");
      close_out(0);
   end
endmodule
`default_nettype wire
